// ===== bench/bdc_master.sv
// behavioural backplane master driving strobes into the slave
`timescale 1ns/1ps
module bdc_master
  import bdc_pkg::*;
(
  // clock
  input  wire logic        ref_clk_i,
  // resolved wires back from the slave
  input  wire logic        dtack_n_i,
  input  wire logic [31:0] data_i,
  // backplane drive
  output bdc_pkg::bdc_bus_s bus_o
);
  import bdc_pkg::*;
  initial bus_o = BUS_IDLE;

  // iack is driven to the caller's value: high for data cycles, low for an acknowledge cycle
  task automatic start(input logic [5:0] am, input logic iack_n, input logic [31:0] a);
    @(posedge ref_clk_i);
    #1;
    bus_o.am     = am;
    bus_o.iack_n = iack_n;
    bus_o.addr   = a[31:1];
    bus_o.as_n   = 1'b0;
  endtask

  // one data strobe cycle; strobes held until acknowledge is sampled or 40 cycles pass
  task automatic beat(input logic [1:0] ds, input logic lw, input logic we, input logic [31:0] wd,
                      output logic ak, output logic [31:0] rd);
    int n;
    @(posedge ref_clk_i);
    #1;
    bus_o.lword_n = lw;
    bus_o.write_n = ~we;
    bus_o.data    = we ? wd : ~bus_o.data;
    bus_o.ds_n    = ds;
    ak = 1'b0;
    rd = '0;
    for (n = 0; n < 40 && !ak; n++) begin
      @(posedge ref_clk_i);
      ak = (dtack_n_i === 1'b0);
      rd = data_i;
    end
    #1;
    bus_o.ds_n = 2'h3;
    bus_o.data = ~bus_o.data;
    // no new strobe until the acknowledge is withdrawn
    if (ak) for (n = 0; n < 40 && dtack_n_i !== 1'b1; n++) @(posedge ref_clk_i);
  endtask

  // release address strobe; address lines no longer hold the old value
  task automatic stop();
    @(posedge ref_clk_i);
    #1;
    bus_o.as_n   = 1'b1;
    bus_o.iack_n = 1'b1;
    bus_o.addr   = ~bus_o.addr;
    repeat (8) @(posedge ref_clk_i);
  endtask
endmodule

// ===== bench/tb_top.sv
// self-checking bench for the data transfer slave
`timescale 1ns/1ps
module tb_top;
  import bdc_pkg::*;
  // modifier codes the slaves are built to decode
  localparam logic [AM_W-1:0] AM_SINGLE = 6'h01;
  localparam logic [AM_W-1:0] AM_BLOCK  = 6'h03;
  logic        ref_clk_i;
  logic        rst_n_i;
  logic        ack_i;
  logic [31:0] rdata_i;
  logic [31:0] data_o;
  logic [1:0]  data_oe_o;
  logic        dtack_n_o;
  logic        dtack_oe_o;
  logic        req_o;
  logic        dt_w;
  logic [31:0] d_w;
  logic        ak;
  logic [31:0] rd;
  bdc_req_s    req_info_o;
  bdc_req_s    rq;
  bdc_bus_s    bus;
  logic [31:0] q_do, o_do;
  logic [1:0]  q_oe, o_oe;
  logic        q_dtn, q_dtoe, q_req, o_dtn, o_dtoe, o_req;
  bdc_req_s    q_info, o_info;
  int          bad_count = 0;
  int          n_tests = 0;
  int          n_req = 0;
  int          cyc = 0;

  bdc_slave dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .bus_i(bus), .data_o(data_o), .data_oe_o(data_oe_o),
                 .dtack_n_o(dtack_n_o), .dtack_oe_o(dtack_oe_o), .req_o(req_o), .req_info_o(req_info_o),
                 .ack_i(ack_i), .rdata_i(rdata_i));
  // a 32-bit slave and an odd-byte-only slave share the backplane
  bdc_slave #(.WIDTH_CLASS(CLS_WORD32), .BASE_ADDR(32'h0002_0000)) dut_q32 (.ref_clk_i(ref_clk_i),
                 .rst_n_i(rst_n_i), .bus_i(bus), .data_o(q_do), .data_oe_o(q_oe), .dtack_n_o(q_dtn),
                 .dtack_oe_o(q_dtoe), .req_o(q_req), .req_info_o(q_info), .ack_i(ack_i), .rdata_i(rdata_i));
  bdc_slave #(.WIDTH_CLASS(CLS_BYTE_ODD), .BASE_ADDR(32'h0001_0000)) dut_odd (.ref_clk_i(ref_clk_i),
                 .rst_n_i(rst_n_i), .bus_i(bus), .data_o(o_do), .data_oe_o(o_oe), .dtack_n_o(o_dtn),
                 .dtack_oe_o(o_dtoe), .req_o(o_req), .req_info_o(o_info), .ack_i(ack_i), .rdata_i(rdata_i));
  bdc_master m (.ref_clk_i(ref_clk_i), .dtack_n_i(dt_w), .data_i(d_w), .bus_o(bus));

  // pulled-up acknowledge; undriven data lines wander every cycle
  assign dt_w = (dtack_oe_o ? dtack_n_o : 1'b1) & (q_dtoe ? q_dtn : 1'b1) & (o_dtoe ? o_dtn : 1'b1);
  assign d_w  = {data_oe_o[1] ? data_o[31:16] : (q_oe[1] ? q_do[31:16] : 16'(cyc)),
                 data_oe_o[0] ? data_o[15:0] : (q_oe[0] ? q_do[15:0] : (o_oe[0] ? o_do[15:0] : ~16'(cyc)))};

  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  // local memory side: capture request, raise ack_i one cycle later for one cycle
  always begin
    @(posedge ref_clk_i);
    #1;
    if (req_o === 1'b1 || q_req === 1'b1 || o_req === 1'b1) begin
      rq = (req_o === 1'b1) ? req_info_o : ((q_req === 1'b1) ? q_info : o_info);
      n_req++;
      @(posedge ref_clk_i);
      #1 ack_i = 1'b1;
      @(posedge ref_clk_i);
      #1 ack_i = 1'b0;
    end
  end

  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      finish_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic t_pair_wr();
    m.start(AM_SINGLE, 1'b1, 32'h1230);
    m.beat(2'h0, 1'b1, 1'b1, 32'h0000BEEF, ak, rd);
    m.stop();
    chk("pw_ack", ak, 1'b1);
    chk("pw_lanes", rq.lanes, LANES_LO);
    chk("pw_addr", rq.addr, 32'h1230);
    chk("pw_data", rq.wdata[31:16], 16'hBEEF);
  endtask

  task automatic t_pair_rd();
    m.start(AM_SINGLE, 1'b1, 32'h1232);
    m.beat(2'h0, 1'b1, 1'b0, 32'h0, ak, rd);
    m.stop();
    chk("pr_lanes", rq.lanes, LANES_HI);
    chk("pr_addr", rq.addr, 32'h1232);
    chk("pr_data", rd[15:0], 16'h3344);
  endtask

  // every single byte lane, even lanes written, odd lanes read
  task automatic t_bytes();
    for (int k = 0; k < 4; k++) begin
      m.start(AM_SINGLE, 1'b1, 32'h1240 + k);
      m.beat(k[0] ? 2'h2 : 2'h1, 1'b1, ~k[0], 32'(8'h60 + k) << 8, ak, rd);
      m.stop();
      chk("b_lanes", rq.lanes, 4'h1 << k);
      chk("b_addr", rq.addr, 32'h1240 + k);
      if (k[0]) chk("b_rd", rd[7:0], (k == 1) ? 8'h22 : 8'h44);
      else chk("b_wd", rq.wdata[31 - 8 * k -: 8], 8'h60 + k);
    end
  endtask

  // interrupt acknowledge, quad on a 16-bit slave, foreign modifier
  task automatic t_refuse();
    int n0;
    for (int i = 0; i < 3; i++) begin
      n0 = n_req;
      m.start((i == 2) ? 6'h02 : AM_SINGLE, i != 0, 32'h1230);
      m.beat(2'h0, i != 1, 1'b1, 32'h0000CAFE, ak, rd);
      m.stop();
      chk("rf_ack", ak, 1'b0);
      chk("rf_req", n_req, n0);
    end
  endtask

  // block ends on the last pair of its 256-byte region
  task automatic t_block();
    m.start(AM_BLOCK, 1'b1, 32'h01FA);
    for (int b = 0; b < 3; b++) begin
      m.beat(2'h0, 1'b1, 1'b1, 32'h0000A000 + b, ak, rd);
      chk("bl_ack", ak, 1'b1);
      chk("bl_addr", rq.addr, 32'h01FA + 2 * b);
    end
    m.stop();
  endtask

  // quad write and read on the 32-bit slave, quad with A01 set refused
  task automatic t_quad();
    int n0;
    m.start(AM_SINGLE, 1'b1, 32'h0002_0010);
    m.beat(2'h0, 1'b0, 1'b1, 32'hA1B2C3D4, ak, rd);
    m.stop();
    chk("q_ack", ak, 1'b1);
    chk("q_lanes", rq.lanes, LANES_QUAD);
    chk("q_wdata", rq.wdata, 32'hA1B2C3D4);
    m.start(AM_SINGLE, 1'b1, 32'h0002_0014);
    m.beat(2'h0, 1'b0, 1'b0, 32'h0, ak, rd);
    m.stop();
    chk("q_rd", rd, 32'h11223344);
    n0 = n_req;
    m.start(AM_SINGLE, 1'b1, 32'h0002_0012);
    m.beat(2'h0, 1'b0, 1'b1, 32'h0, ak, rd);
    m.stop();
    chk("q_a01_ack", ak, 1'b0);
    chk("q_a01_req", n_req, n0);
  endtask

  // odd-only slave: bytes one and three on the low lines, even byte refused
  task automatic t_odd();
    int n0;
    m.start(AM_SINGLE, 1'b1, 32'h0001_0001);
    m.beat(2'h2, 1'b1, 1'b1, 32'h0000005A, ak, rd);
    m.stop();
    chk("o_ack", ak, 1'b1);
    chk("o_lanes", rq.lanes, LANES_B1);
    chk("o_addr", rq.addr, 32'h0001_0001);
    chk("o_wd", rq.wdata[23:16], 8'h5A);
    m.start(AM_SINGLE, 1'b1, 32'h0001_0003);
    m.beat(2'h2, 1'b1, 1'b0, 32'h0, ak, rd);
    m.stop();
    chk("o_rd", rd[7:0], 8'h44);
    n0 = n_req;
    m.start(AM_SINGLE, 1'b1, 32'h0001_0000);
    m.beat(2'h1, 1'b1, 1'b1, 32'h0000A500, ak, rd);
    m.stop();
    chk("o_even_ack", ak, 1'b0);
    chk("o_even_req", n_req, n0);
  endtask

  initial begin
    rst_n_i = 1'b0;
    ack_i   = 1'b0;
    rdata_i = 32'h11223344;
    repeat (16) @(posedge ref_clk_i);
    #1 rst_n_i = 1'b1;
    chk("rst_dtack", dtack_oe_o, 1'b0);
    chk("rst_oe", data_oe_o, OE_NONE);
    t_pair_wr();
    t_block();
    t_pair_rd();
    t_bytes();
    t_refuse();
    t_quad();
    t_odd();
    finish_test();
  end
endmodule

// ===== hw/bdc_pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module bdc_pin_sync #(
  parameter int             W    = 1,
  parameter logic [W-1:0]   IDLE = '0
) (
  // clock and reset
  input  wire logic         ref_clk_i,
  input  wire logic         rst_n_i,
  // pins in, filtered out
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] pin_o
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] out_d;
  logic [W-1:0] out_q;

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      // a bit changes only once the second and third stage agree
      always_comb begin
        out_d[g] = (s2_q[g] == s3_q[g]) ? s3_q[g] : out_q[g];
      end
    end
  endgenerate

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      s1_q  <= IDLE;
      s2_q  <= IDLE;
      s3_q  <= IDLE;
      out_q <= IDLE;
    end else begin
      s1_q  <= pin_i;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      out_q <= out_d;
    end
  end

  assign pin_o = out_q;

endmodule

// ===== hw/bdc_pkg.sv
// shared constants and types for the backplane data transfer slave
package bdc_pkg;

  localparam int          AM_W     = 6;
  localparam int          REGION_W = 8;
  localparam logic [3:0]  LANES_NONE = 4'h0;
  localparam logic [3:0]  LANES_B0   = 4'h1;
  localparam logic [3:0]  LANES_B1   = 4'h2;
  localparam logic [3:0]  LANES_B2   = 4'h4;
  localparam logic [3:0]  LANES_B3   = 4'h8;
  localparam logic [3:0]  LANES_LO   = 4'h3;
  localparam logic [3:0]  LANES_HI   = 4'hC;
  localparam logic [3:0]  LANES_QUAD = 4'hF;
  localparam logic [7:0]  STEP_BYTE  = 8'h01;
  localparam logic [7:0]  STEP_PAIR  = 8'h02;
  localparam logic [7:0]  STEP_QUAD  = 8'h04;
  localparam logic [1:0]  OE_NONE    = 2'h0;
  localparam logic [1:0]  OE_LOW     = 2'h1;
  localparam logic [1:0]  OE_ALL     = 2'h3;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;

  // width classes; an even-byte-only class deliberately does not exist
  typedef enum {CLS_BYTE_EO, CLS_BYTE_ODD, CLS_WORD16, CLS_WORD32} bdc_class_e;

  typedef enum {ST_IDLE, ST_WAIT_DS, ST_ACCESS, ST_ACK, ST_IGNORE} bdc_state_e;

  typedef struct packed {
    logic            as_n;
    logic [1:0]      ds_n;
    logic            lword_n;
    logic            iack_n;
    logic            write_n;
    logic [AM_W-1:0] am;
    logic [31:1]     addr;
    logic [31:0]     data;
  } bdc_bus_s;

  localparam bdc_bus_s BUS_IDLE = '{as_n: 1'h1, ds_n: 2'h3, lword_n: 1'h1, iack_n: 1'h1, write_n: 1'h1,
                                    am: 6'h00, addr: 31'h0000_0000, data: 32'h0000_0000};

  typedef struct packed {
    logic [31:0] addr;
    logic        we;
    logic [3:0]  lanes;
    logic [31:0] wdata;
  } bdc_req_s;

endpackage

// ===== hw/bdc_slave.sv
// data transfer bus slave with width classes and block transfer counter
// Behaviour
// - low acknowledge line marks interrupt acknowledge cycle
// - no answer at all while acknowledge line low; code checks it only in idle and strobe wait, not once the access has started
// - slave has one of four width classes
// - odd-only slave takes bytes one, three only
// - even-odd class takes single bytes zero to three
// - 16-bit class takes byte pairs 0-1, 2-3
// - 32-bit class takes quad bytes 0-3
// - no even-byte-only slave class exists
// - wide classes also accept narrower cycles
// - block start latches address into counter
// - counter advances on every block data strobe
// - block stays inside one 256-byte region
// - decode all six address modifier lines
// - 16-bit slave drives at least low sixteen lines
`timescale 1ns/1ps
module bdc_slave
  import bdc_pkg::*;
#(
  parameter bdc_class_e      WIDTH_CLASS   = CLS_WORD16,
  parameter bit              ACCEPT_NARROW = 1'b1,
  parameter int              ADDR_W        = 24,
  parameter int              WIN_W         = 16,
  parameter logic [31:0]     BASE_ADDR     = 32'h0000_0000,
  parameter logic [AM_W-1:0] AM_SINGLE     = 6'h01,
  parameter logic [AM_W-1:0] AM_BLOCK      = 6'h03
) (
  // clock and reset
  input  wire logic              ref_clk_i,
  input  wire logic              rst_n_i,
  // backplane pins
  input  wire bdc_pkg::bdc_bus_s bus_i,
  output logic [31:0]            data_o,
  output logic [1:0]             data_oe_o,
  output logic                   dtack_n_o,
  output logic                   dtack_oe_o,
  // local access port
  output logic                   req_o,
  output bdc_pkg::bdc_req_s      req_info_o,
  input  wire logic              ack_i,
  input  wire logic [31:0]       rdata_i
);
  import bdc_pkg::*;

  bdc_bus_s   bus_s;
  bdc_state_e state_q, state_d;
  logic [31:0] cnt_q, cnt_d;
  logic [7:0]  nxt_q, nxt_d;
  logic        blk_q, blk_d;
  logic [1:0]  ds_prev_q, ds_prev_d;
  bdc_req_s    req_q, req_d;
  logic        req_pulse_q, req_pulse_d;
  logic [31:0] data_q, data_d;
  logic [1:0]  data_oe_q, data_oe_d;
  logic        dtack_oe_q, dtack_oe_d;
  logic        dtack_n_q;

  logic        as_act, ds_odd, ds_even, ds_any, ds_idle, ds_stable;
  logic        am_ok, hit, a01, single, dbl, quad, legal;
  logic [3:0]  lanes;
  logic [7:0]  step;
  logic [31:0] cur_byte;
  logic [31:0] wmap;

  bdc_pin_sync #(
    .W    ($bits(bdc_bus_s)),
    .IDLE (BUS_IDLE)
  ) u_sync (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .pin_i     (bus_i),
    .pin_o     (bus_s)
  );

  // cycle decode
  always_comb begin
    as_act    = !bus_s.as_n;
    ds_odd    = !bus_s.ds_n[0];
    ds_even   = !bus_s.ds_n[1];
    ds_any    = ds_odd || ds_even;
    ds_idle   = !ds_any;
    // strobes may skew; act only on a pattern held two cycles
    ds_stable = (bus_s.ds_n == ds_prev_q);
    am_ok     = (bus_s.am == AM_SINGLE) || (bus_s.am == AM_BLOCK);
    hit       = (bus_s.addr[ADDR_W-1:WIN_W] == BASE_ADDR[ADDR_W-1:WIN_W]);
    a01       = cnt_q[1];
    single    = (ds_odd ^ ds_even) && bus_s.lword_n;
    dbl       = ds_odd && ds_even && bus_s.lword_n;
    quad      = ds_odd && ds_even && !bus_s.lword_n && !a01;
    lanes     = LANES_NONE;
    step      = STEP_BYTE;
    if (single) begin
      lanes = ds_odd ? (a01 ? LANES_B3 : LANES_B1) : (a01 ? LANES_B2 : LANES_B0);
    end else if (dbl) begin
      lanes = a01 ? LANES_HI : LANES_LO;
      step  = STEP_PAIR;
    end else if (quad) begin
      lanes = LANES_QUAD;
      step  = STEP_QUAD;
    end
    case (WIDTH_CLASS)
      CLS_BYTE_ODD: legal = single && ds_odd;
      CLS_BYTE_EO:  legal = single;
      CLS_WORD16:   legal = dbl || (ACCEPT_NARROW && single);
      default:      legal = quad || (ACCEPT_NARROW && (dbl || single));
    endcase
    cur_byte  = {cnt_q[31:1], single && ds_odd};
    // quad uses all lines; narrower cycles travel on the low sixteen
    if (quad) begin
      wmap = bus_s.data;
    end else if (a01) begin
      wmap = {16'h0000, bus_s.data[15:0]};
    end else begin
      wmap = {bus_s.data[15:0], 16'h0000};
    end
  end

  // cycle sequencer
  always_comb begin
    state_d     = state_q;
    cnt_d       = cnt_q;
    nxt_d       = nxt_q;
    blk_d       = blk_q;
    ds_prev_d   = bus_s.ds_n;
    req_d       = req_q;
    req_pulse_d = 1'b0;
    data_d      = data_q;
    data_oe_d   = data_oe_q;
    dtack_oe_d  = dtack_oe_q;
    case (state_q)
      ST_IDLE: begin
        if (as_act) begin
          if (!bus_s.iack_n || !am_ok || !hit) begin
            state_d = ST_IGNORE;
          end else begin
            cnt_d   = {bus_s.addr, 1'b0};
            blk_d   = (bus_s.am == AM_BLOCK);
            state_d = ST_WAIT_DS;
          end
        end
      end
      ST_WAIT_DS: begin
        if (!as_act) begin
          blk_d   = 1'b0;
          state_d = ST_IDLE;
        end else if (!bus_s.iack_n) begin
          state_d = ST_IGNORE;
        end else if (ds_any && ds_stable) begin
          if (legal) begin
            req_d.addr  = cur_byte;
            req_d.we    = !bus_s.write_n;
            req_d.lanes = lanes;
            req_d.wdata = wmap;
            req_pulse_d = 1'b1;
            // upper bits hold; the low byte wraps inside the region
            nxt_d       = cur_byte[REGION_W-1:0] + step;
            state_d     = ST_ACCESS;
          end else begin
            state_d = ST_IGNORE;
          end
        end
      end
      ST_ACCESS: begin
        if (ack_i) begin
          if (!req_q.we) begin
            if (req_q.lanes == LANES_QUAD) begin
              data_d    = rdata_i;
              data_oe_d = OE_ALL;
            end else begin
              data_d    = {16'h0000, req_q.lanes[3] || req_q.lanes[2] ? rdata_i[15:0] : rdata_i[31:16]};
              data_oe_d = OE_LOW;
            end
          end
          dtack_oe_d = 1'b1;
          state_d    = ST_ACK;
        end
      end
      ST_ACK: begin
        if (ds_idle) begin
          dtack_oe_d = 1'b0;
          data_oe_d  = OE_NONE;
          if (blk_q) begin
            cnt_d   = {cnt_q[31:REGION_W], nxt_q};
            state_d = ST_WAIT_DS;
          end else begin
            state_d = ST_IGNORE;
          end
        end
      end
      default: begin
        if (!as_act) begin
          blk_d   = 1'b0;
          state_d = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      state_q     <= ST_IDLE;
      cnt_q       <= WORD_RESET;
      nxt_q       <= 8'h00;
      blk_q       <= 1'b0;
      ds_prev_q   <= 2'h3;
      req_q       <= '0;
      req_pulse_q <= 1'b0;
      data_q      <= WORD_RESET;
      data_oe_q   <= OE_NONE;
      dtack_oe_q  <= 1'b0;
      dtack_n_q   <= 1'b0;
    end else begin
      state_q     <= state_d;
      cnt_q       <= cnt_d;
      nxt_q       <= nxt_d;
      blk_q       <= blk_d;
      ds_prev_q   <= ds_prev_d;
      req_q       <= req_d;
      req_pulse_q <= req_pulse_d;
      data_q      <= data_d;
      data_oe_q   <= data_oe_d;
      dtack_oe_q  <= dtack_oe_d;
      dtack_n_q   <= 1'b0;
    end
  end

  assign data_o     = data_q;
  assign data_oe_o  = data_oe_q;
  assign dtack_n_o  = dtack_n_q;
  assign dtack_oe_o = dtack_oe_q;
  assign req_o      = req_pulse_q;
  assign req_info_o = req_q;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_iack_start;
    state_q == ST_IDLE && as_act && !bus_s.iack_n;
  endsequence
  sequence s_access_done;
    state_q == ST_ACCESS && ack_i;
  endsequence
  sequence s_block_release;
    state_q == ST_ACK && ds_idle && blk_q;
  endsequence

  property p_iack_class;
    s_iack_start |=> state_q == ST_IGNORE;
  endproperty
  a_iack_class: assert property (p_iack_class) else $error("acknowledge cycle not classified");

  property p_iack_silent;
    s_iack_start |=> (!dtack_oe_q && data_oe_q == OE_NONE && !req_o) [*2];
  endproperty
  a_iack_silent: assert property (p_iack_silent) else $error("answered while acknowledge low");

  property p_odd_lanes;
    req_o && WIDTH_CLASS == CLS_BYTE_ODD |-> req_info_o.lanes == LANES_B1 || req_info_o.lanes == LANES_B3;
  endproperty
  a_odd_lanes: assert property (p_odd_lanes) else $error("odd-only slave took even lane");

  property p_quad_class;
    req_o && req_info_o.lanes == LANES_QUAD |-> WIDTH_CLASS == CLS_WORD32;
  endproperty
  a_quad_class: assert property (p_quad_class) else $error("quad cycle taken by narrow class");

  property p_illegal_ignored;
    state_q == ST_WAIT_DS && as_act && bus_s.iack_n && ds_any && ds_stable && !legal
      |=> state_q == ST_IGNORE && !dtack_oe_q;
  endproperty
  a_illegal_ignored: assert property (p_illegal_ignored) else $error("out-of-class cycle not ignored");

  property p_capture;
    state_q == ST_IDLE && as_act && bus_s.iack_n && am_ok && hit |=> cnt_q == {$past(bus_s.addr), 1'b0};
  endproperty
  a_capture: assert property (p_capture) else $error("start address not latched");

  property p_advance;
    s_block_release |=> cnt_q != $past(cnt_q) && cnt_q[31:REGION_W] == $past(cnt_q[31:REGION_W]);
  endproperty
  a_advance: assert property (p_advance) else $error("block counter step wrong");

  property p_ack_then_release;
    s_access_done |=> dtack_oe_q ##1 (dtack_oe_q || ds_idle);
  endproperty
  a_ack_then_release: assert property (p_ack_then_release) else $error("acknowledge lost early");

  property p_read_low_lines;
    (s_access_done and !req_q.we) |=> data_oe_q[0];
  endproperty
  a_read_low_lines: assert property (p_read_low_lines) else $error("read not driven on low lines");

  property p_as_clear;
    !as_act && (state_q == ST_WAIT_DS || state_q == ST_IGNORE) |=> state_q == ST_IDLE && !blk_q;
  endproperty
  a_as_clear: assert property (p_as_clear) else $error("strobe release did not clear");

endmodule
